// File: fault_sleep_pkg.sv
// constants, enumerations and summary for the fault escalation and sleep control block
// Summary of operation
// - vector read bus error becomes hard fault
// - memory mismatch flags per access kind
// - no-execute fetch faults even without protection
// - bus error flags per access kind
// - six usage fault causes, own flags
// - fault at or below current priority escalates
// - disabled handler fault escalates to hard fault
// - stacking bus fault entering bus handler stays
// - hard fault fixed priority, preempts all others
// - other faults have configurable priority, enable
// - capture address of memory and bus faults
// - hard fault in nmi or hard handler locks
// - lockup ends on reset, nmi or halt
// - nmi does not release lockup from nmi
// - light sleep gates core clock, deep stops all
// - wait for interrupt sleeps unless wake pending
// - wait for event consumes flag or sleeps
// - send event sets hidden event flag
// - sleep after last handler returns
// - wake on exception able to enter, or as below
// - masked higher priority interrupt wakes if fault mask clear
// - event wake, new pending wakes when enabled
package fault_sleep_pkg;
	localparam int ADDR_W   = 32;            // fault address width
	localparam int PRIO_W   = 3;             // configurable priority width
	// hard fault status bit positions
	localparam int HF_VECTOR_READ_ERROR_FLAG  = 0;
	localparam int HF_ESC   = 1;
	localparam int HF_W     = 2;
	// memory manage status bit positions
	localparam int MM_INSTR = 0;
	localparam int MM_DATA  = 1;
	localparam int MM_STK   = 2;
	localparam int MM_UNSTK = 3;
	localparam int MM_W     = 4;
	// bus fault status bit positions
	localparam int BF_STK   = 0;
	localparam int BF_UNSTK = 1;
	localparam int BF_PREF  = 2;
	localparam int BF_PREC  = 3;
	localparam int BF_DEFER = 4;
	localparam int BF_W     = 5;
	// usage fault status bit positions
	localparam int UF_COPROC = 0;
	localparam int UF_UNKNOWN_OPCODE_FLAG  = 1;
	localparam int UF_STATE  = 2;
	localparam int UF_RETVAL = 3;
	localparam int UF_ALIGN  = 4;
	localparam int UF_ZERO_DIVISOR_FLAG   = 5;
	localparam int UF_W      = 6;
	// fault class codes of the current handler
	localparam logic [2:0] CTX_THREAD = 3'h0;
	localparam logic [2:0] CTX_NMI    = 3'h1;
	localparam logic [2:0] CTX_HARD   = 3'h2;
	localparam logic [2:0] CTX_MEM    = 3'h3;
	localparam logic [2:0] CTX_BUS    = 3'h4;
	localparam logic [2:0] CTX_USAGE  = 3'h5;
	localparam logic [2:0] CTX_OTHER  = 3'h6;
	// fault routing result
	typedef enum logic [2:0] {
		RT_NONE, RT_HARD, RT_MEM, RT_BUS, RT_USAGE
	} route_e;
	// reset values
	localparam logic [ADDR_W-1:0] ADDR_RST = 32'h0000_0000;
endpackage

// File: sticky_flags.sv
// sticky status flag bank, set beats clear
`timescale 1ns/10ps
module sticky_flags #(
	parameter int W = 4
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] set,   // hardware set pulses
	input  wire logic [W-1:0] clr,   // software clear pulses
	output logic      [W-1:0] q      // registered flags
);
	logic [W-1:0] nxt_q;             // next flag value
	// set wins so an event in the clear cycle is kept
	assign nxt_q = (q & ~clr) | set;
	// flag storage
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) q <= '0;
		else        q <= nxt_q;
	end
	// a set pulse always shows next cycle even with a clear
	property p_set_wins;
		@(posedge clk) disable iff (!rst_b) (|set) |=> ((q & $past(set)) == $past(set));
	endproperty
	a_set_wins: assert property (p_set_wins) else $error("sticky flag lost a set");
	property p_hold;
		@(posedge clk) disable iff (!rst_b) (set == '0 && clr == '0) |=> $stable(q);
	endproperty
	a_hold: assert property (p_hold) else $error("sticky flag changed without cause");
endmodule // sticky_flags

// File: fault_addr_capture.sv
// fault address capture register
`timescale 1ns/10ps
module fault_addr_capture #(
	parameter int AW = 32
) (
	input  wire logic          clk,
	input  wire logic          rst_b,
	input  wire logic          cap,    // capture strobe
	input  wire logic [AW-1:0] addr,   // faulting address
	output logic      [AW-1:0] q,      // captured address
	output logic               valid   // address holds a capture
);
	// latch address on each faulting access, newest wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			q     <= '0;
			valid <= 1'b0;
		end else if (cap) begin
			q     <= addr;
			valid <= 1'b1;
		end
	end
	property p_cap;
		@(posedge clk) disable iff (!rst_b) cap |=> (q == $past(addr)) && valid;
	endproperty
	a_cap: assert property (p_cap) else $error("fault address not captured");
endmodule // fault_addr_capture

// File: fault_escalation_sleep_control.sv
// fault classification, escalation, lockup and sleep control top
`timescale 1ns/10ps
module fault_escalation_sleep_control
	import fault_sleep_pkg::*;
(
	input  wire logic                         CLOCK,
	input  wire logic                         RST_B,
	// error reports from the pipeline and bus checks, one-cycle pulses
	input  wire logic                         VECTOR_BUS_ERR,
	input  wire logic [fault_sleep_pkg::MM_W-1:0] MEM_VIOL,
	input  wire logic                         NO_EXECUTE_REGION_FETCH,
	input  wire logic [fault_sleep_pkg::BF_W-1:0] BUS_ERR,
	input  wire logic [fault_sleep_pkg::UF_W-1:0] USAGE_ERR,
	input  wire logic [fault_sleep_pkg::ADDR_W-1:0] FAULT_ADDR_IN,
	// current execution context
	input  wire logic [2:0]                   CUR_CTX,
	input  wire logic [fault_sleep_pkg::PRIO_W-1:0] CUR_PRIO,
	input  wire logic                         ENTERING_BUS_HANDLER,
	// software configuration
	input  wire logic [fault_sleep_pkg::PRIO_W-1:0] MEM_PRIO,
	input  wire logic [fault_sleep_pkg::PRIO_W-1:0] BUS_PRIO,
	input  wire logic [fault_sleep_pkg::PRIO_W-1:0] USAGE_PRIO,
	input  wire logic                         MEM_HANDLER_EN,
	input  wire logic                         BUS_HANDLER_EN,
	input  wire logic                         USAGE_HANDLER_EN,
	input  wire logic                         DEEP_SLEEP_SELECT,
	input  wire logic                         SLEEP_AFTER_HANDLERS,
	input  wire logic                         EVENT_ON_NEW_PENDING,
	// software clears of the sticky status
	input  wire logic [fault_sleep_pkg::HF_W-1:0] HARD_CLR,
	input  wire logic [fault_sleep_pkg::MM_W-1:0] MEM_CLR,
	input  wire logic [fault_sleep_pkg::BF_W-1:0] BUS_CLR,
	input  wire logic [fault_sleep_pkg::UF_W-1:0] USAGE_CLR,
	// instructions and interrupt controller inputs
	input  wire logic                         WAIT_FOR_INTERRUPT_INSTR,
	input  wire logic                         WAIT_FOR_EVENT_INSTR,
	input  wire logic                         SEND_EVENT_INSTR,
	input  wire logic                         LAST_HANDLER_RETURN,
	input  wire logic                         ENTRY_ABLE_EXC,
	input  wire logic                         MASKED_HIGHER_IRQ,
	input  wire logic                         INTERRUPT_MASK_BIT,
	input  wire logic                         FAULT_MASK_BIT,
	input  wire logic                         NEW_PENDING_IRQ,
	input  wire logic                         NMI_REQ,
	input  wire logic                         DEBUG_HALT,
	// outputs
	output logic [fault_sleep_pkg::HF_W-1:0]  HARD_FAULT_STATUS,
	output logic [fault_sleep_pkg::MM_W-1:0]  MEMORY_MANAGE_FAULT_STATUS,
	output logic [fault_sleep_pkg::BF_W-1:0]  BUS_FAULT_STATUS,
	output logic [fault_sleep_pkg::UF_W-1:0]  USAGE_FAULT_STATUS,
	output logic [fault_sleep_pkg::ADDR_W-1:0] MEMORY_MANAGE_FAULT_ADDRESS,
	output logic [fault_sleep_pkg::ADDR_W-1:0] BUS_FAULT_ADDRESS,
	output logic                              HARD_FAULT_TAKE,
	output logic                              MEM_FAULT_TAKE,
	output logic                              BUS_FAULT_TAKE,
	output logic                              USAGE_FAULT_TAKE,
	output logic                              LOCKUP,
	output logic                              CORE_CLK_GATE,
	output logic                              SYS_CLK_STOP,
	output logic                              PLL_FLASH_OFF,
	output logic                              SLEEPING,
	output logic                              HANDLER_HOLD
);
	import fault_sleep_pkg::*;

	// sleep state machine
	typedef enum logic [1:0] { S_RUN, S_SLEEP_WFI, S_SLEEP_WFE } sleep_e;

	// true when a fault of priority p may not preempt the current level
	function automatic logic cannot_preempt(input logic [PRIO_W-1:0] p,
	                                        input logic [PRIO_W-1:0] cur,
	                                        input logic [2:0] ctx);
		// lower number is higher priority; thread mode never blocks
		// nmi and hard handlers sit above every configurable level
		cannot_preempt = (ctx == CTX_NMI) || (ctx == CTX_HARD) ||
		                 ((ctx != CTX_THREAD) && (p >= cur));
	endfunction

	// raw fault detection per class
	logic [MM_W-1:0] mem_set;      // memory manage causes this cycle
	logic            mem_any;      // any memory manage cause
	logic            bus_any;      // any bus error cause
	logic            usage_any;    // any usage cause
	logic            mem_esc;      // memory fault must escalate
	logic            bus_esc;      // bus fault must escalate
	logic            usage_esc;    // usage fault must escalate
	logic            bus_exempt;   // stacking error while entering bus handler
	logic            esc_any;      // any escalation this cycle
	logic            hard_req;     // hard fault requested
	logic            in_nmi_hard;  // current handler is nmi or hard fault
	logic [HF_W-1:0] hard_set;     // hard fault status sets
	logic [HF_W-1:0] hard_q;       // hard status flags
	logic [MM_W-1:0] mem_q;        // memory manage flags
	logic [BF_W-1:0] bus_q;        // bus fault flags
	logic [UF_W-1:0] usage_q;      // usage fault flags
	logic [ADDR_W-1:0] mm_addr_q;  // captured memory fault address
	logic [ADDR_W-1:0] bf_addr_q;  // captured bus fault address
	logic            bus_addr_cap; // capture strobe for bus address

	// no-execute fetch counts as instruction violation, unit on or off
	assign mem_set   = MEM_VIOL | {{(MM_W-1){1'b0}}, NO_EXECUTE_REGION_FETCH};
	assign mem_any   = |mem_set;
	assign bus_any   = |BUS_ERR;
	assign usage_any = |USAGE_ERR;

	// stacking error on the way into the bus handler keeps its own handler
	assign bus_exempt = ENTERING_BUS_HANDLER && BUS_ERR[BF_STK];

	// escalation: handler disabled or no preemption possible
	assign mem_esc   = mem_any && (!MEM_HANDLER_EN ||
	                   cannot_preempt(MEM_PRIO, CUR_PRIO, CUR_CTX));
	assign bus_esc   = bus_any && !bus_exempt && (!BUS_HANDLER_EN ||
	                   cannot_preempt(BUS_PRIO, CUR_PRIO, CUR_CTX));
	assign usage_esc = usage_any && (!USAGE_HANDLER_EN ||
	                   cannot_preempt(USAGE_PRIO, CUR_PRIO, CUR_CTX));
	assign esc_any   = mem_esc || bus_esc || usage_esc;

	// hard fault sources: vector read error or escalation
	assign hard_req  = VECTOR_BUS_ERR || esc_any;
	assign hard_set  = {esc_any, VECTOR_BUS_ERR};
	assign in_nmi_hard = (CUR_CTX == CTX_NMI) || (CUR_CTX == CTX_HARD);

	// sticky status banks
	sticky_flags #(.W(HF_W)) u_hard (
		.clk(CLOCK), .rst_b(RST_B), .set(hard_set), .clr(HARD_CLR), .q(hard_q)
	);
	sticky_flags #(.W(MM_W)) u_mem (
		.clk(CLOCK), .rst_b(RST_B), .set(mem_set), .clr(MEM_CLR), .q(mem_q)
	);
	sticky_flags #(.W(BF_W)) u_bus (
		.clk(CLOCK), .rst_b(RST_B), .set(BUS_ERR), .clr(BUS_CLR), .q(bus_q)
	);
	sticky_flags #(.W(UF_W)) u_usage (
		.clk(CLOCK), .rst_b(RST_B), .set(USAGE_ERR), .clr(USAGE_CLR), .q(usage_q)
	);

	// deferred data errors carry no reliable address
	assign bus_addr_cap = bus_any && !(BUS_ERR == (BF_W'(1) << BF_DEFER));
	fault_addr_capture #(.AW(ADDR_W)) u_mm_addr (
		.clk(CLOCK), .rst_b(RST_B), .cap(mem_any), .addr(FAULT_ADDR_IN),
		.q(mm_addr_q), .valid()
	);
	fault_addr_capture #(.AW(ADDR_W)) u_bf_addr (
		.clk(CLOCK), .rst_b(RST_B), .cap(bus_addr_cap), .addr(FAULT_ADDR_IN),
		.q(bf_addr_q), .valid()
	);

	// lockup state
	logic lockup_ff;       // core locked up
	logic lock_from_nmi_ff;// lockup was entered from nmi handler
	logic nxt_lockup;
	logic nxt_lock_from_nmi;
	logic lock_enter;
	logic lock_release;
	assign lock_enter   = hard_req && in_nmi_hard && !lockup_ff;
	// nmi frees only a lockup that began outside the nmi handler
	assign lock_release = DEBUG_HALT || (NMI_REQ && !lock_from_nmi_ff);
	assign nxt_lockup   = lock_enter ? 1'b1 : (lock_release ? 1'b0 : lockup_ff);
	assign nxt_lock_from_nmi = lock_enter ? (CUR_CTX == CTX_NMI) :
	                           (lock_release ? 1'b0 : lock_from_nmi_ff);
	// lockup register
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			lockup_ff        <= 1'b0;
			lock_from_nmi_ff <= 1'b0;
		end else begin
			lockup_ff        <= nxt_lockup;
			lock_from_nmi_ff <= nxt_lock_from_nmi;
		end
	end

	// fault routing; hard fault beats every configurable fault
	route_e route;
	assign route = (hard_req && !in_nmi_hard) ? RT_HARD :
	               (hard_req)                 ? RT_NONE :
	               mem_any                    ? RT_MEM :
	               bus_any                    ? RT_BUS :
	               usage_any                  ? RT_USAGE : RT_NONE;

	// event flag and sleep machine
	sleep_e state_ff;
	sleep_e nxt_state;
	logic   event_ff;      // internal event flag, no software path
	logic   nxt_event;
	logic   wake_irq;      // wake for wfi and sleep after handlers
	logic   wake_evt;      // wake for wfe
	logic   new_pend_evt;  // pend event when enabled
	logic   wfi_go;
	logic   wfe_go;
	logic   exit_go;
	assign wake_irq     = ENTRY_ABLE_EXC ||
	                      (MASKED_HIGHER_IRQ && INTERRUPT_MASK_BIT && !FAULT_MASK_BIT);
	assign new_pend_evt = EVENT_ON_NEW_PENDING && NEW_PENDING_IRQ;
	assign wake_evt     = wake_irq || new_pend_evt || SEND_EVENT_INSTR;
	assign wfi_go  = (state_ff == S_RUN) && !lockup_ff && WAIT_FOR_INTERRUPT_INSTR && !wake_irq;
	assign wfe_go  = (state_ff == S_RUN) && !lockup_ff && WAIT_FOR_EVENT_INSTR && !event_ff &&
	                 !wake_evt;
	assign exit_go = (state_ff == S_RUN) && !lockup_ff && SLEEP_AFTER_HANDLERS &&
	                 LAST_HANDLER_RETURN && !wake_irq;

	// event flag: send event or pend event sets, a running wfe consumes it
	assign nxt_event = (SEND_EVENT_INSTR || new_pend_evt) ? 1'b1 :
	                   ((state_ff == S_RUN && WAIT_FOR_EVENT_INSTR) ? 1'b0 :
	                   ((state_ff == S_SLEEP_WFE && wake_evt) ? 1'b0 : event_ff));

	// sleep state transitions
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			S_RUN: begin
				if (wfi_go || exit_go) nxt_state = S_SLEEP_WFI;
				else if (wfe_go)       nxt_state = S_SLEEP_WFE;
			end
			S_SLEEP_WFI: begin
				if (wake_irq || DEBUG_HALT) nxt_state = S_RUN;
			end
			S_SLEEP_WFE: begin
				if (wake_evt || DEBUG_HALT) nxt_state = S_RUN;
			end
			default: nxt_state = S_RUN;
		endcase
	end

	// sleep and event registers
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			state_ff <= S_RUN;
			event_ff <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			event_ff <= nxt_event;
		end
	end

	// registered outputs; clock controls follow the sleep mode
	logic asleep_nxt;
	assign asleep_nxt = (nxt_state != S_RUN);
	always_ff @(posedge CLOCK or negedge RST_B) begin
		if (!RST_B) begin
			HARD_FAULT_TAKE  <= 1'b0;
			MEM_FAULT_TAKE   <= 1'b0;
			BUS_FAULT_TAKE   <= 1'b0;
			USAGE_FAULT_TAKE <= 1'b0;
			CORE_CLK_GATE    <= 1'b0;
			SYS_CLK_STOP     <= 1'b0;
			PLL_FLASH_OFF    <= 1'b0;
			SLEEPING         <= 1'b0;
			HANDLER_HOLD     <= 1'b0;
		end else begin
			HARD_FAULT_TAKE  <= (route == RT_HARD);
			MEM_FAULT_TAKE   <= (route == RT_MEM);
			BUS_FAULT_TAKE   <= (route == RT_BUS);
			USAGE_FAULT_TAKE <= (route == RT_USAGE);
			CORE_CLK_GATE    <= asleep_nxt;
			SYS_CLK_STOP     <= asleep_nxt && DEEP_SLEEP_SELECT;
			PLL_FLASH_OFF    <= asleep_nxt && DEEP_SLEEP_SELECT;
			SLEEPING         <= asleep_nxt;
			// woke by a masked interrupt: handler waits for mask clear
			HANDLER_HOLD     <= INTERRUPT_MASK_BIT && !FAULT_MASK_BIT && MASKED_HIGHER_IRQ;
		end
	end
	assign HARD_FAULT_STATUS           = hard_q;
	assign MEMORY_MANAGE_FAULT_STATUS  = mem_q;
	assign BUS_FAULT_STATUS            = bus_q;
	assign USAGE_FAULT_STATUS          = usage_q;
	assign MEMORY_MANAGE_FAULT_ADDRESS = mm_addr_q;
	assign BUS_FAULT_ADDRESS           = bf_addr_q;
	assign LOCKUP                      = lockup_ff;

	// assertions
	property p_vector_read_error_flag;
		@(posedge CLOCK) disable iff (!RST_B) VECTOR_BUS_ERR |=> HARD_FAULT_STATUS[HF_VECTOR_READ_ERROR_FLAG];
	endproperty
	a_vector_read_error_flag: assert property (p_vector_read_error_flag) else $error("vector error flag missing");
	property p_xn;
		@(posedge CLOCK) disable iff (!RST_B)
			NO_EXECUTE_REGION_FETCH |=> MEMORY_MANAGE_FAULT_STATUS[MM_INSTR];
	endproperty
	a_xn: assert property (p_xn) else $error("no-execute fetch not flagged");
	property p_disabled_esc;
		@(posedge CLOCK) disable iff (!RST_B)
			(usage_any && !USAGE_HANDLER_EN) |=> HARD_FAULT_STATUS[HF_ESC] && !USAGE_FAULT_TAKE;
	endproperty
	a_disabled_esc: assert property (p_disabled_esc) else $error("disabled fault not escalated");
	// a memory or usage fault inside the nmi or hard handler never gets its own handler
	property p_nmi_hard_esc;
		@(posedge CLOCK) disable iff (!RST_B)
			(in_nmi_hard && (mem_any || usage_any)) |=>
			HARD_FAULT_STATUS[HF_ESC] && !MEM_FAULT_TAKE && !USAGE_FAULT_TAKE;
	endproperty
	a_nmi_hard_esc: assert property (p_nmi_hard_esc) else $error("not escalated");
	property p_bus_exempt;
		@(posedge CLOCK) disable iff (!RST_B)
			(BUS_ERR == (BF_W'(1) << BF_STK) && ENTERING_BUS_HANDLER && !VECTOR_BUS_ERR &&
			 !mem_esc && !usage_esc && !mem_any) |=> BUS_FAULT_TAKE;
	endproperty
	a_bus_exempt: assert property (p_bus_exempt) else $error("bus handler entry fault escalated");
	property p_lock;
		@(posedge CLOCK) disable iff (!RST_B)
			(hard_req && in_nmi_hard && !lock_release) |=> LOCKUP;
	endproperty
	a_lock: assert property (p_lock) else $error("lockup not entered");
	property p_nmi_stays;
		@(posedge CLOCK) disable iff (!RST_B)
			(LOCKUP && lock_from_nmi_ff && !DEBUG_HALT) |=> LOCKUP;
	endproperty
	a_nmi_stays: assert property (p_nmi_stays) else $error("nmi released nmi lockup");
	property p_release;
		@(posedge CLOCK) disable iff (!RST_B) (LOCKUP && DEBUG_HALT && !lock_enter) |=> !LOCKUP;
	endproperty
	a_release: assert property (p_release) else $error("halt did not release lockup");
	property p_wfi;
		@(posedge CLOCK) disable iff (!RST_B) wfi_go |=> SLEEPING && CORE_CLK_GATE;
	endproperty
	a_wfi: assert property (p_wfi) else $error("wfi did not sleep");
	property p_wfe_flag;
		@(posedge CLOCK) disable iff (!RST_B)
			(state_ff == S_RUN && WAIT_FOR_EVENT_INSTR && event_ff && !SEND_EVENT_INSTR &&
			 !new_pend_evt) |=> !event_ff && !SLEEPING;
	endproperty
	a_wfe_flag: assert property (p_wfe_flag) else $error("wfe with event slept");
	property p_deep;
		@(posedge CLOCK) disable iff (!RST_B) SYS_CLK_STOP |-> CORE_CLK_GATE && PLL_FLASH_OFF;
	endproperty
	a_deep: assert property (p_deep) else $error("deep sleep incomplete");
	property p_wake;
		@(posedge CLOCK) disable iff (!RST_B) (state_ff == S_SLEEP_WFI && wake_irq) |=> !SLEEPING;
	endproperty
	a_wake: assert property (p_wake) else $error("no wake on entry-able exception");
	// send event always leaves the hidden flag set
	property p_event_set;
		@(posedge CLOCK) disable iff (!RST_B) SEND_EVENT_INSTR |=> event_ff;
	endproperty
	a_event_set: assert property (p_event_set) else $error("event flag not set");
	// a new pending interrupt with the enable set ends wait-for-event sleep
	property p_pend_wake;
		@(posedge CLOCK) disable iff (!RST_B)
			(state_ff == S_SLEEP_WFE && new_pend_evt) |=> !SLEEPING;
	endproperty
	a_pend_wake: assert property (p_pend_wake) else $error("pending event did not wake");
	c_lock:  cover property (@(posedge CLOCK) disable iff (!RST_B) lock_enter ##[1:20] lock_release);
	c_wfe:   cover property (@(posedge CLOCK) disable iff (!RST_B) wfe_go ##[1:20] !SLEEPING);
	c_esc:   cover property (@(posedge CLOCK) disable iff (!RST_B) esc_any && !in_nmi_hard);
	c_deep:  cover property (@(posedge CLOCK) disable iff (!RST_B) SYS_CLK_STOP);
endmodule // fault_escalation_sleep_control

// File: irq_model.sv
// interrupt controller stand-in that raises an entry-able exception after a chosen lag
`timescale 1ns/10ps
module irq_model (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [3:0] lag,        // cycles from request to exception, 1 prompt, 8 slow
	input  wire logic       req,        // bench asks for an exception
	output logic            entry_able  // exception able to cause entry
);
	logic [3:0] cnt_ff;                 // lag counter, holds at lag once reached
	// count while requested; dropping the request withdraws the exception at the next edge
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_ff     <= 4'h0;
			entry_able <= 1'b0;
		end else if (!req) begin
			cnt_ff     <= 4'h0;
			entry_able <= 1'b0;
		end else if (cnt_ff != lag) begin
			cnt_ff     <= cnt_ff + 4'h1;
			entry_able <= (cnt_ff + 4'h1) == lag;
		end
	end
endmodule // irq_model

// File: tb_fault_escalation_sleep_control.sv
// self-checking bench for fault escalation, lockup and sleep control
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module tb_fault_escalation_sleep_control;
	import fault_sleep_pkg::*;
	logic clock = 1'b0, rst_b = 1'b0, vbe = 1'b0, nxf = 1'b0, ebh = 1'b0, bhe = 1'b1, dss = 1'b0;
	logic sah = 1'b0, eonp = 1'b0, wait_for_interrupt_instr = 1'b0, wait_for_event_instr = 1'b0, send_event_instr = 1'b0, lhr = 1'b0, mhi = 1'b0;
	logic imb = 1'b0, npi = 1'b0, nmi = 1'b0, dbg = 1'b0, req = 1'b0;
	logic he = 1'b1, fmb = 1'b0;        // memory and usage handler enable, fault mask
	logic [3:0] mv = 4'h0, mc = 4'h0, lag = 4'h1;
	logic [4:0] be = 5'h0, bc = 5'h0;
	logic [5:0] ue = 6'h0, uc = 6'h0;
	logic [1:0] hc = 2'h0;
	logic [31:0] addr = 32'h0, ea;
	logic [2:0] ctx = CTX_THREAD, cp = 3'h7, mp = 3'h4;
	wire logic [1:0] hfs;
	wire logic [3:0] mms;
	wire logic [4:0] bfs;
	wire logic [5:0] ufs;
	wire logic [31:0] mma, bfa;
	wire logic hft, mft, bft, uft, lk, cg, scs, pfo, slp, hh, eae;
	int num_errors = 0, compares = 0;
	always #4 clock = ~clock;           // 125 MHz
	fault_escalation_sleep_control u_dut (.CLOCK(clock), .RST_B(rst_b), .VECTOR_BUS_ERR(vbe),
		.MEM_VIOL(mv), .NO_EXECUTE_REGION_FETCH(nxf), .BUS_ERR(be), .USAGE_ERR(ue),
		.FAULT_ADDR_IN(addr), .CUR_CTX(ctx), .CUR_PRIO(cp), .ENTERING_BUS_HANDLER(ebh),
		.MEM_PRIO(mp), .BUS_PRIO(3'h4), .USAGE_PRIO(3'h4), .MEM_HANDLER_EN(he),
		.BUS_HANDLER_EN(bhe), .USAGE_HANDLER_EN(he), .DEEP_SLEEP_SELECT(dss),
		.SLEEP_AFTER_HANDLERS(sah), .EVENT_ON_NEW_PENDING(eonp), .HARD_CLR(hc), .MEM_CLR(mc),
		.BUS_CLR(bc), .USAGE_CLR(uc), .WAIT_FOR_INTERRUPT_INSTR(wait_for_interrupt_instr), .WAIT_FOR_EVENT_INSTR(wait_for_event_instr),
		.SEND_EVENT_INSTR(send_event_instr), .LAST_HANDLER_RETURN(lhr), .ENTRY_ABLE_EXC(eae),
		.MASKED_HIGHER_IRQ(mhi), .INTERRUPT_MASK_BIT(imb), .FAULT_MASK_BIT(fmb),
		.NEW_PENDING_IRQ(npi), .NMI_REQ(nmi), .DEBUG_HALT(dbg), .HARD_FAULT_STATUS(hfs),
		.MEMORY_MANAGE_FAULT_STATUS(mms), .BUS_FAULT_STATUS(bfs), .USAGE_FAULT_STATUS(ufs),
		.MEMORY_MANAGE_FAULT_ADDRESS(mma), .BUS_FAULT_ADDRESS(bfa), .HARD_FAULT_TAKE(hft),
		.MEM_FAULT_TAKE(mft), .BUS_FAULT_TAKE(bft), .USAGE_FAULT_TAKE(uft), .LOCKUP(lk),
		.CORE_CLK_GATE(cg), .SYS_CLK_STOP(scs), .PLL_FLASH_OFF(pfo), .SLEEPING(slp),
		.HANDLER_HOLD(hh));
	irq_model u_irq (.clk(clock), .rst_b(rst_b), .lag(lag), .req(req), .entry_able(eae));
	// inputs always move one nanosecond after the rising edge
	task tick;
		@(posedge clock);
		#1;
	endtask
	// software wipes every sticky flag, then releases the clears
	task wipe;
		{hc, mc, bc, uc} = '1;
		tick;
		{hc, mc, bc, uc} = '0;
		tick;
	endtask
	// ask for an exception and confirm sleep still holds when it shows, then ends a cycle later
	task wake;
		req = 1'b1;
		for (int k = 0; k < 20 && eae !== 1'b1; k++) tick;
		`CHK(slp, 1'b1)
		tick;
		`CHK(slp, 1'b0)
	endtask
	task print_verdict;
		$display("compares=%0d num_errors=%0d", compares, num_errors);
		if (num_errors == 0 && compares > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	// watchdog: the whole sequence needs well under a thousand cycles
	initial begin
		#200000;
		num_errors++;
		print_verdict;
	end
	initial begin
		repeat (4) @(posedge clock);
		#1 rst_b = 1'b1;
		tick;
		for (int i = 0; i < 6; i++) begin
			ue = 6'h1 << i;
			tick;
			ue = 6'h0;
			`CHK(ufs, 6'h1 << i)
			`CHK(uft, 1'b1)
			tick;
			`CHK(ufs, 6'h1 << i)
			wipe;
			`CHK(ufs, 6'h0)
		end
		{ue, uc} = {6'h4, 6'h4};        // event and clear in one cycle: the event is kept
		tick;
		{ue, uc} = '0;
		`CHK(ufs, 6'h4)
		for (int i = 0; i < 9; i++) begin
			addr = 32'hA5C3_0100 + 32'(i * 4);
			if (i != 8) ea = addr;      // deferred error leaves the captured address alone
			if (i < 4) mv = 4'h1 << i;
			else be = 5'h1 << (i - 4);
			tick;
			{mv, be} = '0;
			if (i < 4) `CHK({mms, mft, mma}, {4'h1 << i, 1'b1, ea})
			else `CHK({bfs, bft, bfa}, {5'h1 << (i - 4), 1'b1, ea})
			wipe;
		end
		nxf = 1'b1;
		tick;
		nxf = 1'b0;
		`CHK({mms, mft}, {4'h1, 1'b1})
		vbe = 1'b1;
		tick;
		vbe = 1'b0;
		`CHK({hfs, hft}, {2'h1, 1'b1})
		wipe;
		ctx = CTX_USAGE;
		cp = 3'h4;
		mp = 3'h2;                      // more urgent than the running handler: no escalation
		mv = 4'h2;
		tick;
		mv = 4'h0;
		`CHK({hfs, hft, mft}, {2'h0, 1'b0, 1'b1})
		ue = 6'h20;                     // same priority as the running handler
		tick;
		ue = 6'h0;
		`CHK({hfs, hft, uft}, {2'h2, 1'b1, 1'b0})
		wipe;
		ctx = CTX_BUS;
		ebh = 1'b1;
		be = 5'h1;
		tick;
		{be, ebh} = '0;
		`CHK({hfs, hft, bft}, {2'h0, 1'b0, 1'b1})
		ctx = CTX_THREAD;
		bhe = 1'b0;
		be = 5'h8;
		tick;
		be = 5'h0;
		`CHK({hfs, hft, bft}, {2'h2, 1'b1, 1'b0})
		bhe = 1'b1;
		he = 1'b0;                      // memory and usage handlers switched off
		mv = 4'h2;
		ue = 6'h2;
		tick;
		{he, mv, ue} = {1'b1, 4'h0, 6'h0};
		`CHK({hfs, hft, mft, uft}, {2'h2, 1'b1, 1'b0, 1'b0})
		wipe;
		cp = 3'h7;                      // least urgent level: only the handler kind decides
		for (int i = 0; i < 2; i++) begin
			ctx = i ? CTX_NMI : CTX_HARD;
			vbe = i[0];                 // vector error in nmi, usage fault in hard handler
			ue = {5'h0, ~i[0]};
			tick;
			{vbe, ue} = '0;
			`CHK({lk, hft, uft}, {1'b1, 1'b0, 1'b0})
			nmi = 1'b1;
			tick;
			nmi = 1'b0;
			`CHK(lk, i ? 1'b1 : 1'b0)
			dbg = 1'b1;
			tick;
			dbg = 1'b0;
			`CHK(lk, 1'b0)
		end
		ctx = CTX_THREAD;
		wipe;
		for (int d = 0; d < 2; d++) begin
			dss = d[0];
			lag = d ? 4'h8 : 4'h1;
			wait_for_interrupt_instr = 1'b1;
			tick;
			wait_for_interrupt_instr = 1'b0;
			`CHK({slp, cg, scs, pfo}, {2'h3, d[0], d[0]})
			wake;
			wait_for_interrupt_instr = 1'b1;                 // wake already pending
			tick;
			{wait_for_interrupt_instr, req} = '0;
			`CHK(slp, 1'b0)
			tick;                       // let the withdrawn exception fall before the next wfi
		end
		send_event_instr = 1'b1;
		tick;
		send_event_instr = 1'b0;
		wait_for_event_instr = 1'b1;
		tick;
		`CHK(slp, 1'b0)
		tick;
		wait_for_event_instr = 1'b0;
		`CHK(slp, 1'b1)
		for (int i = 0; i < 2; i++) begin
			eonp = i[0];
			npi = 1'b1;
			tick;
			npi = 1'b0;
			tick;
			`CHK(slp, ~i[0])
		end
		{eonp, sah, lhr} = 3'h7;
		ctx = CTX_OTHER;
		tick;
		{ctx, lhr} = '0;
		`CHK(slp, 1'b1)
		{imb, mhi} = 2'h3;
		tick;
		tick;
		`CHK({slp, hh}, {1'b0, 1'b1})
		fmb = 1'b1;                     // fault mask set: no masked-wake hold
		tick;
		`CHK(hh, 1'b0)
		print_verdict;
	end
endmodule // tb_fault_escalation_sleep_control
